// [verification/fcps_flash_host_props.sv]
`timescale 1ns/1ns
module fcps_flash_host_props
    import fcps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic [fcps_pkg::ADDR_W-1:0] o_flash_addr,
    input wire logic [fcps_pkg::DATA_W-1:0] o_flash_dq_out,
    input wire logic o_flash_dq_oe,
    input wire logic o_flash_ce_n,
    input wire logic o_flash_we_n,
    input wire logic o_flash_oe_n,
    input wire logic o_flash_reset_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready too long");
    a_ready_wait: assert property ($rose(i_penable) && i_psel |=> o_pready) else $error("pready late");
    a_write_pins: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n && o_flash_dq_oe) else $error("bad write pins");
    a_no_contend: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && o_flash_we_n) else $error("bus contention");
    a_we_width: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n [*4] ##1 o_flash_we_n) else $error("strobe width");
    a_write_hold: assert property (!o_flash_we_n |=> o_flash_we_n || ($stable(o_flash_addr) && $stable(o_flash_dq_out)))
        else $error("write lines moved");
    a_data_at_rise: assert property ($rose(o_flash_we_n) |-> o_flash_dq_oe && $stable(o_flash_dq_out)) else $error("data lost");
    a_reset_width: assert property ($fell(o_flash_reset_n) |-> !o_flash_reset_n [*8]) else $error("reset pulse short");
    c_write: cover property ($fell(o_flash_we_n));
    c_read: cover property ($fell(o_flash_oe_n));
    c_reset: cover property ($fell(o_flash_reset_n));
endmodule : fcps_flash_host_props
bind fcps_flash_host fcps_flash_host_props i_props (.i_clk, .i_rst, .i_psel, .i_penable, .o_pready, .o_flash_addr,
    .o_flash_dq_out, .o_flash_dq_oe, .o_flash_ce_n, .o_flash_we_n, .o_flash_oe_n, .o_flash_reset_n);

// [verification/fcps_flash_host_test.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: %h", $time, g); end end
module fcps_flash_host_test;
    import fcps_pkg::*;
    localparam logic [15:0] MFR = 16'h00c3;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, dq_oe, ce_n, we_n, oe_n, rst_n, byte_n;
    logic [DATA_W-1:0] dq_in, dq_out, m_dq;
    logic [ADDR_W-1:0] f_addr;
    int failures = 0;
    int n_checks = 0;
    always #5 i_clk = ~i_clk;
    assign dq_in = dq_oe ? dq_out : m_dq;
    fcps_flash_host i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_flash_dq(dq_in), .o_flash_addr(f_addr), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe),
        .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n), .o_flash_reset_n(rst_n),
        .o_flash_byte_n(byte_n));
    fcps_flash_model #(.MFR_CODE(MFR)) i_flash (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_reset_n(rst_n),
        .i_byte_n(byte_n), .i_addr(f_addr), .i_dq(dq_in), .o_dq(m_dq));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic run(input logic [4:0] c);
        apb(1'b1, REG_CTRL, {1'b1, 26'h0, c});
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
    endtask : run
    task automatic rdf(input logic [ADDR_W-1:0] a);
        apb(1'b1, REG_ADDR, {6'h00, a});
        run(5'h05);
        apb(1'b0, REG_RDATA, 32'h0);
    endtask : rdf
    task automatic prog(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [15:0] e);
        apb(1'b1, REG_ADDR, {6'h00, a});
        apb(1'b1, REG_DATA, {16'h0, d});
        run(5'h02);
        `CHK(rd[3:0], 4'b0010)
        rdf(a);
        `CHK(rd[15:0], e)
    endtask : prog
    task automatic t_regs;
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd, REG_RST)
        apb(1'b0, 12'h040, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, REG_COUNT, 32'hffffffff);
        apb(1'b0, REG_COUNT, 32'h0);
        `CHK(rd, 32'h0000001f)
    endtask : t_regs
    task automatic t_ident;
        run(5'h10);
        rdf(26'h0);
        `CHK(rd[15:0], MFR)
        rdf(26'h0);
        `CHK(rd[15:0], MFR)
        apb(1'b1, REG_ADDR, 32'h00012345);
        run(5'h01);
        rdf(26'h0);
        `CHK(rd[15:0], 16'hffff)
        run(5'h00);
        run(5'h01);
    endtask : t_ident
    task automatic t_prog;
        prog(26'h0010040, 16'h1234, 16'h1234);
        prog(26'h0010040, 16'hff00, 16'h1200);
        prog(26'h0000007, 16'h5a5a, 16'h5a5a);
        apb(1'b1, REG_CTRL, {1'b1, 28'h0, 3'h2});
        apb(1'b1, REG_CTRL, {1'b1, 28'h0, 3'h0});
        `CHK(err, 1'b1)
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
        rdf(26'h0000007);
        `CHK(rd[15:0], 16'h5a5a)
    endtask : t_prog
    task automatic t_buf;
        // start near the page top so the word index wraps inside the page
        apb(1'b1, REG_ADDR, 32'h0002003e);
        apb(1'b1, REG_COUNT, 32'h0000001f);
        for (int i = 0; i < BUF_WORDS; i++) apb(1'b1, 12'h080 + 12'(4 * i), {16'h0, 16'h0a00 + 16'(i)});
        run(5'h03);
        `CHK(rd[3:0], 4'b0010)
        for (int i = 0; i < BUF_WORDS; i++) begin
            rdf({21'h001001, 5'(5'h1e + i)});
            `CHK(rd[15:0], 16'h0a00 + 16'(i))
        end
    endtask : t_buf
    task automatic t_hwreset;
        run(5'h06);
        `CHK(rst_n, 1'b1)
        prog(26'h0010041, 16'h00ff, 16'h00ff);
        run(5'h04);
        `CHK(rd[3:0], 4'b0010)
    endtask : t_hwreset
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        t_ident;
        t_prog;
        t_buf;
        t_hwreset;
        report_and_stop;
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        failures++;
        report_and_stop;
    end
endmodule : fcps_flash_host_test

// [verification/fcps_flash_model.sv]
`timescale 1ns/1ns
module fcps_flash_model
    import fcps_pkg::*;
#(
    parameter logic [15:0] MFR_CODE = 16'h00c3, // arbitrary value
    parameter int SEC_LSB = 16
)
(
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic i_reset_n,
    input wire logic i_byte_n,
    input wire logic [fcps_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fcps_pkg::DATA_W-1:0] i_dq,
    output logic [fcps_pkg::DATA_W-1:0] o_dq
);
    logic [15:0] mem [logic [ADDR_W-1:0]];
    logic [15:0] bufm [logic [ADDR_W-1:0]];
    logic [15:0] rdv = 16'h0000;
    logic [15:0] ld = 16'h0000;
    logic [ADDR_W-1:0] wa, sec, fa;
    logic tg = 1'b0;
    logic ab = 1'b0;
    logic idm = 1'b0;
    int st = 0;
    int busy = 0;
    int cnt = 0;
    wire [ADDR_W-1:0] ua1 = i_byte_n ? WA_UNLOCK1 : BA_UNLOCK1;
    wire [ADDR_W-1:0] ua2 = i_byte_n ? WA_UNLOCK2 : BA_UNLOCK2;
    always @(negedge i_we_n) wa = i_addr;
    always @(posedge i_we_n or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st = 0;
            busy = 0;
            ab = 1'b0;
            idm = 1'b0;
        end else if (busy == 0) begin
            if (st == 0 && i_dq == DQ_EXIT) idm = 1'b0;
            case (st)
                0: st = (i_dq == DQ_UNLOCK1 && wa == ua1) ? 1 : 0;
                1: st = (i_dq == DQ_UNLOCK2 && wa == ua2) ? 2 : 0;
                2: begin
                    st = 0;
                    if (i_dq == DQ_EXIT) ab = 1'b0;
                    else if (!ab && wa == ua1 && i_dq == DQ_IDENT) idm = 1'b1;
                    else if (!ab && wa == ua1 && i_dq == DQ_PROG) st = 3;
                    else if (!ab && i_dq == DQ_BUF_LOAD) st = 4;
                    sec = wa;
                end
                3: begin
                    mem[wa] = (mem.exists(wa) ? mem[wa] : 16'hffff) & i_dq;
                    ld = i_dq;
                    busy = 3;
                    st = 0;
                end
                4: begin
                    bufm.delete();
                    cnt = i_dq + 1;
                    st = (i_dq > BUF_WORDS - 1) ? 9 : 5;
                end
                5: begin
                    if (bufm.size() == 0) fa = wa;
                    bufm[wa] = i_dq;
                    ld = i_dq;
                    cnt--;
                    st = (cnt == 0) ? 6 : 5;
                    if (wa[ADDR_W-1:SEC_LSB] != sec[ADDR_W-1:SEC_LSB]) st = 9;
                    if (wa[ADDR_W-1:PAGE_LSB] != fa[ADDR_W-1:PAGE_LSB]) st = 9;
                end
                default: begin
                    st = (i_dq == DQ_BUF_CONFIRM && wa[ADDR_W-1:SEC_LSB] == sec[ADDR_W-1:SEC_LSB]) ? 0 : 9;
                    foreach (bufm[a]) mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & bufm[a];
                    busy = 3;
                end
            endcase
            if (st == 9) begin
                ab = 1'b1;
                st = 0;
            end
        end
    end
    // access time before the answer so that the address has settled
    always @(negedge i_oe_n) begin
        #1;
        tg = ~tg;
        if (ab) rdv = {8'h00, ~ld[7], tg, 4'h0, 2'b10};
        else if (busy > 0) rdv = {8'h00, ~ld[7], tg, 6'h00};
        else if (idm) rdv = (i_addr[7:0] == 8'h00) ? MFR_CODE : 16'h0000;
        else rdv = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
        if (busy > 0) busy--;
    end
    assign o_dq = (i_oe_n || i_ce_n) ? ~rdv : rdv;
endmodule : fcps_flash_model

// [verilog/fcps_bus_cycle.sv]
`timescale 1ns/1ns
module fcps_bus_cycle
    import fcps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input fcps_pkg::fcps_req_t i_req,
    input wire logic [fcps_pkg::DATA_W-1:0] i_flash_dq,
    output logic o_ready,
    output logic o_done,
    output logic [fcps_pkg::DATA_W-1:0] o_rdata,
    output logic [fcps_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [fcps_pkg::DATA_W-1:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    output logic o_flash_ce_n,
    output logic o_flash_we_n,
    output logic o_flash_oe_n,
    output logic o_flash_reset_n
);
    logic busy_q, rec_q;
    fcps_kind_t kind_q;
    logic [TCNT_W-1:0] cnt_q, act_len, rec_len;
    logic [DATA_W-1:0] dq_s1_q, dq_s2_q;

    assign act_len = (i_req.kind == K_WRITE) ? TCNT_W'(WE_LOW_CYC) :
                     (i_req.kind == K_READ) ? TCNT_W'(ACCESS_CYC) : TCNT_W'(RESET_LOW_CYC);
    assign rec_len = (kind_q == K_RESET) ? TCNT_W'(RESET_READY_CYC) : TCNT_W'(RECOVER_CYC);
    assign o_ready = ~busy_q;

    always_ff @(posedge i_clk) begin
        dq_s1_q <= i_flash_dq;
        dq_s2_q <= dq_s1_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            rec_q <= 1'b0;
            kind_q <= K_WRITE;
            cnt_q <= '0;
            o_done <= 1'b0;
            o_rdata <= '0;
            o_flash_addr <= '0;
            o_flash_dq_out <= '0;
            o_flash_dq_oe <= 1'b0;
            o_flash_ce_n <= 1'b1;
            o_flash_we_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            o_flash_reset_n <= 1'b1;
        end else begin
            o_done <= 1'b0;
            if (!busy_q) begin
                if (i_req_valid) begin
                    busy_q <= 1'b1;
                    rec_q <= 1'b0;
                    kind_q <= i_req.kind;
                    cnt_q <= act_len;
                    o_flash_addr <= i_req.addr;
                    o_flash_dq_out <= i_req.data;
                    o_flash_dq_oe <= (i_req.kind == K_WRITE);
                    o_flash_ce_n <= (i_req.kind == K_RESET);
                    o_flash_oe_n <= (i_req.kind != K_READ);
                    o_flash_reset_n <= (i_req.kind != K_RESET);
                end
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
                // one cycle of address setup before the strobe falls
                if (!rec_q && kind_q == K_WRITE) begin
                    o_flash_we_n <= 1'b0;
                end
            end else if (!rec_q) begin
                rec_q <= 1'b0 | 1'b1;
                cnt_q <= rec_len;
                // both strobes rise together, data still driven through recovery
                o_flash_we_n <= 1'b1;
                o_flash_ce_n <= 1'b1;
                o_flash_oe_n <= 1'b1;
                o_flash_reset_n <= 1'b1;
                if (kind_q == K_READ) begin
                    o_rdata <= dq_s2_q;
                end
            end else begin
                busy_q <= 1'b0;
                o_flash_dq_oe <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end
endmodule : fcps_bus_cycle

// [verilog/fcps_flash_host.sv]
`timescale 1ns/1ns
// Functional notes
// - identification entry: AA at 555, 55 at 2AA, 90 at 555; byte mode AAA/555
// - F0 written anywhere leaves identification mode for array read
// - writes hold chip select and write strobe low, output gate high
// - single program: AA, 55, A0 at unlock addresses, then data at target
// - hardware reset aborts programming; repeat the whole sequence afterwards
// - buffer program: two unlocks, load command, count minus one, at sector
// - after counted loads the confirm command at sector, anything else aborts
// - host polls polarity, toggle, timeout, alternate toggle and abort at last address; only toggle, timeout and abort are judged
// - in unlock bypass an abort needs the abort reset sequence
// - buffer load command word is 25 at the sector address
// - buffer confirm command word is 29 at the sector address
// - abort reset: AA at 555, 55 at 2AA, F0 at 555
module fcps_flash_host
    import fcps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [fcps_pkg::PADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic [fcps_pkg::DATA_W-1:0] i_flash_dq,
    output logic [fcps_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [fcps_pkg::DATA_W-1:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    output logic o_flash_ce_n,
    output logic o_flash_we_n,
    output logic o_flash_oe_n,
    output logic o_flash_reset_n,
    output logic o_flash_byte_n
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ISSUE = 2'b01,
        S_WAIT = 2'b11
    } fcps_state_t;

    function automatic logic [ADDR_W-1:0] fcps_unlock_addr(input logic byte_m, input logic second);
        if (byte_m) begin
            fcps_unlock_addr = second ? BA_UNLOCK2 : BA_UNLOCK1;
        end else begin
            fcps_unlock_addr = second ? WA_UNLOCK2 : WA_UNLOCK1;
        end
    endfunction : fcps_unlock_addr

    // keeps every load inside the page chosen by the first one
    function automatic logic [ADDR_W-1:0] fcps_page_addr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] idx);
        fcps_page_addr = {a[ADDR_W-1:PAGE_LSB], CNT_W'(a[PAGE_LSB-1:0] + idx)};
    endfunction : fcps_page_addr

    function automatic logic [5:0] fcps_last_step(input fcps_cmd_t cmd, input logic [CNT_W-1:0] cnt);
        case (cmd)
            CMD_ID_ENTRY: fcps_last_step = 6'd2;
            CMD_PROG: fcps_last_step = 6'd3;
            CMD_BUF_PROG: fcps_last_step = 6'(cnt) + 6'd5;
            CMD_ABORT_RST: fcps_last_step = 6'd2;
            default: fcps_last_step = 6'd0;
        endcase
    endfunction : fcps_last_step

    function automatic fcps_req_t fcps_step_req(input fcps_cmd_t cmd, input logic [5:0] step, input logic byte_m,
                                                input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                                input logic [CNT_W-1:0] cnt, input logic [DATA_W-1:0] bw);
        fcps_req_t r;
        r.kind = K_WRITE;
        r.addr = a;
        r.data = d;
        case (cmd)
            CMD_ID_EXIT: r.data = DQ_EXIT;
            CMD_READ: r.kind = K_READ;
            CMD_HW_RESET: r.kind = K_RESET;
            CMD_ID_ENTRY, CMD_PROG, CMD_BUF_PROG, CMD_ABORT_RST: begin
                if (step == 6'd0) begin
                    r.addr = fcps_unlock_addr(byte_m, 1'b0);
                    r.data = DQ_UNLOCK1;
                end else if (step == 6'd1) begin
                    r.addr = fcps_unlock_addr(byte_m, 1'b1);
                    r.data = DQ_UNLOCK2;
                end else if (step == 6'd2) begin
                    r.addr = (cmd == CMD_BUF_PROG) ? a : fcps_unlock_addr(byte_m, 1'b0);
                    r.data = (cmd == CMD_ID_ENTRY) ? DQ_IDENT :
                             (cmd == CMD_PROG) ? DQ_PROG :
                             (cmd == CMD_BUF_PROG) ? DQ_BUF_LOAD : DQ_EXIT;
                end else if (cmd == CMD_PROG) begin
                    r.data = d;
                end else if (step == 6'd3) begin
                    // a 5-bit count can never exceed the buffer
                    r.data = DATA_W'(cnt);
                end else if (step == fcps_last_step(cmd, cnt)) begin
                    r.data = DQ_BUF_CONFIRM;
                end else begin
                    r.addr = fcps_page_addr(a, CNT_W'(step - 6'd4));
                    r.data = bw;
                end
            end
            default: r.kind = K_READ;
        endcase
        return r;
    endfunction : fcps_step_req

    fcps_state_t state_q, state_d;
    fcps_cmd_t cmd_q;
    logic byte_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q, rdata_q, prev_q, last_q;
    logic [CNT_W-1:0] count_q;
    logic [DATA_W-1:0] buf_q [BUF_WORDS];
    logic [5:0] step_q;
    logic polling_q, have_prev_q;
    logic done_q, abort_q, fail_q;

    wire apb_setup = i_psel & i_penable & ~o_pready;
    wire apb_wr = i_psel & i_penable & o_pready & i_pwrite;
    wire in_buf = (i_paddr[PADDR_W-1:7] == REG_BUF_PAGE);
    wire [CNT_W-1:0] buf_idx = i_paddr[6:2];
    wire hit_ctrl = (i_paddr == REG_CTRL);
    wire hit_st = (i_paddr == REG_STATUS);
    wire mapped = hit_ctrl | hit_st | in_buf | (i_paddr == REG_ADDR) | (i_paddr == REG_DATA) |
                  (i_paddr == REG_COUNT) | (i_paddr == REG_RDATA);
    wire busy = (state_q != S_IDLE);
    // commands while busy are refused so the device never sees a broken sequence
    wire go_req = hit_ctrl & i_pwdata[CTRL_GO_BIT];
    wire go = apb_wr & go_req & ~busy & ~o_pslverr;
    wire refuse = ~mapped | (i_pwrite & go_req & busy);

    wire [31:0] status_word = {last_q, 12'h000, fail_q, abort_q, done_q, busy};
    wire [31:0] rd_word = hit_ctrl ? {27'h0, byte_q, 1'b0, cmd_q} :
                          (i_paddr == REG_ADDR) ? 32'(addr_q) :
                          (i_paddr == REG_DATA) ? 32'(data_q) :
                          (i_paddr == REG_COUNT) ? 32'(count_q) :
                          hit_st ? status_word :
                          (i_paddr == REG_RDATA) ? 32'(rdata_q) :
                          in_buf ? 32'(buf_q[buf_idx]) : REG_RST;

    wire [ADDR_W-1:0] poll_addr = (cmd_q == CMD_BUF_PROG) ? fcps_page_addr(addr_q, count_q) : addr_q;
    wire [5:0] last_step = fcps_last_step(cmd_q, count_q);
    wire [CNT_W-1:0] load_idx = CNT_W'(step_q - 6'd4);
    fcps_req_t step_req, eng_req;
    assign step_req = fcps_step_req(cmd_q, step_q, byte_q, addr_q, data_q, count_q, buf_q[load_idx]);
    assign eng_req = polling_q ? '{kind: K_READ, addr: poll_addr, data: '0} : step_req;
    wire eng_valid = (state_q == S_ISSUE);

    logic eng_ready, eng_done;
    logic [DATA_W-1:0] eng_rdata;
    fcps_poll_t poll;

    fcps_bus_cycle u_cycle (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_req_valid(eng_valid),
        .i_req(eng_req),
        .i_flash_dq(i_flash_dq),
        .o_ready(eng_ready),
        .o_done(eng_done),
        .o_rdata(eng_rdata),
        .o_flash_addr(o_flash_addr),
        .o_flash_dq_out(o_flash_dq_out),
        .o_flash_dq_oe(o_flash_dq_oe),
        .o_flash_ce_n(o_flash_ce_n),
        .o_flash_we_n(o_flash_we_n),
        .o_flash_oe_n(o_flash_oe_n),
        .o_flash_reset_n(o_flash_reset_n)
    );

    fcps_poll_check u_poll (
        .i_prev(prev_q),
        .i_cur(eng_rdata),
        .o_poll(poll)
    );

    wire seq_end = eng_done & ~polling_q & (step_q == last_step);
    wire poll_end = eng_done & polling_q & have_prev_q & (poll.done | poll.abort | poll.fail);
    // program commands end only when polling sees the device stop toggling, abort or fail
    wire need_poll = (cmd_q == CMD_PROG) | (cmd_q == CMD_BUF_PROG);
    wire finish = poll_end | (seq_end & ~need_poll);
    wire st_clr = apb_wr & hit_st;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: if (go) state_d = S_ISSUE;
            S_ISSUE: if (eng_ready) state_d = S_WAIT;
            S_WAIT: if (eng_done) state_d = finish ? S_IDLE : S_ISSUE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= REG_RST;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= apb_setup;
            o_prdata <= apb_setup ? rd_word : REG_RST;
            o_pslverr <= apb_setup & refuse;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cmd_q <= CMD_ID_ENTRY;
            byte_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            count_q <= '0;
            o_flash_byte_n <= 1'b1;
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_q[i] <= '0;
            end
        end else begin
            if (go) begin
                cmd_q <= fcps_cmd_t'(i_pwdata[CTRL_CMD_LSB +: 3]);
                byte_q <= i_pwdata[CTRL_BYTE_BIT];
                o_flash_byte_n <= ~i_pwdata[CTRL_BYTE_BIT];
            end
            if (apb_wr && !busy && i_paddr == REG_ADDR) addr_q <= i_pwdata[ADDR_W-1:0];
            if (apb_wr && !busy && i_paddr == REG_DATA) data_q <= i_pwdata[DATA_W-1:0];
            if (apb_wr && !busy && i_paddr == REG_COUNT) count_q <= i_pwdata[CNT_W-1:0];
            if (apb_wr && !busy && in_buf) buf_q[buf_idx] <= i_pwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            step_q <= '0;
            polling_q <= 1'b0;
            have_prev_q <= 1'b0;
            prev_q <= '0;
            rdata_q <= '0;
            last_q <= '0;
        end else begin
            state_q <= state_d;
            if (go) begin
                step_q <= '0;
                polling_q <= 1'b0;
                have_prev_q <= 1'b0;
            end else if (eng_done && polling_q) begin
                have_prev_q <= 1'b1;
                prev_q <= eng_rdata;
                last_q <= eng_rdata;
            end else if (eng_done && step_q == last_step) begin
                polling_q <= need_poll;
                if (cmd_q == CMD_READ) rdata_q <= eng_rdata;
            end else if (eng_done) begin
                step_q <= step_q + 6'd1;
            end
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_q <= 1'b0;
            abort_q <= 1'b0;
            fail_q <= 1'b0;
        end else if (go) begin
            done_q <= 1'b0;
            abort_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            done_q <= finish | (done_q & ~(st_clr & i_pwdata[ST_DONE_BIT]));
            abort_q <= (poll_end & poll.abort) | (abort_q & ~(st_clr & i_pwdata[ST_ABORT_BIT]));
            fail_q <= (poll_end & poll.fail) | (fail_q & ~(st_clr & i_pwdata[ST_FAIL_BIT]));
        end
    end
endmodule : fcps_flash_host

// [verilog/fcps_pkg.sv]
package fcps_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int BUF_WORDS = 32;
    localparam int CNT_W = 5;
    localparam int PADDR_W = 12;

    // pin timing; least times round up to whole cycles
    localparam int T_WE_LOW_NS = 35;
    localparam int T_RECOVER_NS = 20;
    localparam int T_ACCESS_NS = 110;
    localparam int T_RESET_LOW_NS = 500;
    localparam int T_RESET_READY_NS = 20000;
    localparam int SYNC_CYC = 2;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
    localparam int RESET_LOW_CYC = (T_RESET_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_READY_CYC = (T_RESET_READY_NS * CLK_MHZ + 999) / 1000;
    localparam int TCNT_W = 12;

    // command words and unlock addresses
    localparam logic [DATA_W-1:0] DQ_UNLOCK1 = 16'h00aa;
    localparam logic [DATA_W-1:0] DQ_UNLOCK2 = 16'h0055;
    localparam logic [DATA_W-1:0] DQ_IDENT = 16'h0090;
    localparam logic [DATA_W-1:0] DQ_EXIT = 16'h00f0;
    localparam logic [DATA_W-1:0] DQ_PROG = 16'h00a0;
    localparam logic [DATA_W-1:0] DQ_BUF_LOAD = 16'h0025;
    localparam logic [DATA_W-1:0] DQ_BUF_CONFIRM = 16'h0029;
    localparam logic [ADDR_W-1:0] WA_UNLOCK1 = 26'h0000555;
    localparam logic [ADDR_W-1:0] WA_UNLOCK2 = 26'h00002aa;
    localparam logic [ADDR_W-1:0] BA_UNLOCK1 = 26'h0000aaa;
    localparam logic [ADDR_W-1:0] BA_UNLOCK2 = 26'h0000555;
    localparam int PAGE_LSB = 5;

    // status bit positions on the data bus
    localparam int DQ_POLARITY_BIT = 7;
    localparam int DQ_TOGGLE_BIT = 6;
    localparam int DQ_TIMEOUT_BIT = 5;
    localparam int DQ_ALT_TOGGLE_BIT = 2;
    localparam int DQ_ABORT_BIT = 1;

    // register map
    localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] REG_ADDR = 12'h004;
    localparam logic [PADDR_W-1:0] REG_DATA = 12'h008;
    localparam logic [PADDR_W-1:0] REG_COUNT = 12'h00c;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h010;
    localparam logic [PADDR_W-1:0] REG_RDATA = 12'h014;
    localparam logic [4:0] REG_BUF_PAGE = 5'h01;
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_BYTE_BIT = 4;
    localparam int CTRL_GO_BIT = 31;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ABORT_BIT = 2;
    localparam int ST_FAIL_BIT = 3;
    localparam int ST_LAST_LSB = 16;
    localparam logic [31:0] REG_RST = 32'h00000000;

    typedef enum logic [2:0] {
        CMD_ID_ENTRY = 3'h0,
        CMD_ID_EXIT = 3'h1,
        CMD_PROG = 3'h2,
        CMD_BUF_PROG = 3'h3,
        CMD_ABORT_RST = 3'h4,
        CMD_READ = 3'h5,
        CMD_HW_RESET = 3'h6
    } fcps_cmd_t;

    typedef enum logic [1:0] {
        K_WRITE = 2'h0,
        K_READ = 2'h1,
        K_RESET = 2'h2
    } fcps_kind_t;

    typedef struct packed {
        fcps_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcps_req_t;

    typedef struct packed {
        logic done;
        logic abort;
        logic fail;
    } fcps_poll_t;
endpackage : fcps_pkg

// [verilog/fcps_poll_check.sv]
`timescale 1ns/1ns
module fcps_poll_check
    import fcps_pkg::*;
(
    input wire logic [fcps_pkg::DATA_W-1:0] i_prev,
    input wire logic [fcps_pkg::DATA_W-1:0] i_cur,
    output fcps_pkg::fcps_poll_t o_poll
);
    // judged from two successive status reads at the same address
    wire toggling = i_prev[DQ_TOGGLE_BIT] ^ i_cur[DQ_TOGGLE_BIT];
    assign o_poll.done = ~toggling;
    // abort flag on both reads, so array data after completion cannot fake it
    assign o_poll.abort = toggling & i_prev[DQ_ABORT_BIT] & i_cur[DQ_ABORT_BIT];
    // timeout seen on both reads, still toggling and no abort flag on the second read counts as a real failure
    assign o_poll.fail = toggling & ~i_cur[DQ_ABORT_BIT] & i_prev[DQ_TIMEOUT_BIT] & i_cur[DQ_TIMEOUT_BIT];
endmodule : fcps_poll_check
